/* File: verilog/bma_alu.sv */
// Bit-manipulation ALU: decode, field datapath and registered result
//
// Functional notes
// - Signed extract takes rs1[min(len+pos,31):pos], sign-extended from field top.
// - Unsigned extract takes the same field and zero-extends it.
// - Register forms take length-minus-one from rs2[9:5], start from rs2[4:0].
// - Deposit writes low rs1 bits into the field; other old destination bits stay.
// - Clear forces the field to zero; other bits copy rs1.
// - Set forces the field to one; other bits copy rs1.
// - Find-first-one gives lowest set bit index, 32 for zero.
// - Find-last-one gives highest set bit index, 32 for zero.
// - Leading sign count is run of MSB-equal bits minus one; zero gives 0.
// - Population count returns number of ones in rs1.
// - Bit reverse swaps groups of one, two or three bits by selector.
// - Group selector 3 behaves as selector 0.
// - Bit reverse yields the FFT index for 2^(32-pos) points, radix 2^(sel+1).
// - Immediate field ops: opcode 1011011, funct3 000, subop selects ext/extu/deposit.
// - Funct3 001 subop selects clear, set or bit reverse with zero pad bits.
// - Register field ops: opcode 0101011, funct3 011, funct7 selects operation.
// - Funct7 0100000..0100100 select rotate, ff1, fl1, clb, count; rs2 field zero except for rotate.
// - Bit reverse first shifts left by position, discarding top bits.
// - Operations exist only when the custom extension parameter equals one.
`timescale 1ns/1ns
module bma_alu
    import bma_pkg::*;
#(
    parameter int custom_ext_param = EXT_ENABLED
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire bma_req_s req,
    output bma_rsp_s rsp
);

    function automatic bma_op_e decode_op(bma_instr_s ins);
        logic [6:0] funct7;
        bma_op_e op;
        funct7 = {ins.subop_select, ins.length_imm};
        op = OP_NONE;
        if (ins.opcode == OPC_FIELD_IMM && ins.funct3 == F3_EXT_DEP)
        begin
            case (ins.subop_select)
                F2_EXT_S: op = OP_EXT_S;
                F2_EXT_U: op = OP_EXT_U;
                F2_DEPOSIT: op = OP_DEPOSIT;
                default: op = OP_NONE;
            endcase
        end
        else if (ins.opcode == OPC_FIELD_IMM && ins.funct3 == F3_CLR_SET)
        begin
            case (ins.subop_select)
                F2_CLR: op = OP_CLR;
                F2_SET: op = OP_SET;
                F2_BITREV:
                begin
                    // Nonzero pad bits make the word illegal
                    if (ins.length_imm[4:2] == BITREV_PAD)
                    begin
                        op = OP_BITREV;
                    end
                end
                default: op = OP_NONE;
            endcase
        end
        else if (ins.opcode == OPC_FIELD_REG && ins.funct3 == F3_REG)
        begin
            case (funct7)
                F7_EXT_S: op = OP_EXT_S;
                F7_EXT_U: op = OP_EXT_U;
                F7_DEPOSIT: op = OP_DEPOSIT;
                F7_CLR: op = OP_CLR;
                F7_SET: op = OP_SET;
                F7_ROR: op = OP_ROR;
                F7_FF1: op = OP_FF1;
                F7_FL1: op = OP_FL1;
                F7_CLB: op = OP_CLB;
                F7_CNT: op = OP_CNT;
                default: op = OP_NONE;
            endcase
            // Unary forms need the rs2 field clear
            if ((op == OP_FF1 || op == OP_FL1 || op == OP_CLB ||
                 op == OP_CNT) && ins.position_imm != RS2_NONE)
            begin
                op = OP_NONE;
            end
        end
        // Upper rs2 bits never reach decode, only the field selects
        return op;
    endfunction : decode_op

    function automatic logic [5:0] find_first(bma_word_t w);
        logic [5:0] idx;
        idx = WORD_BITS;
        for (int i = XLEN - 1; i >= 0; i--)
        begin
            if (w[i])
            begin
                idx = 6'(i);
            end
        end
        return idx;
    endfunction : find_first

    function automatic logic [5:0] find_last(bma_word_t w);
        logic [5:0] idx;
        idx = WORD_BITS;
        for (int i = 0; i < XLEN; i++)
        begin
            if (w[i])
            begin
                idx = 6'(i);
            end
        end
        return idx;
    endfunction : find_last

    function automatic logic [5:0] lead_sign(bma_word_t w);
        logic [5:0] run;
        logic stop;
        run = COUNT_ZERO;
        stop = 1'b0;
        for (int i = XLEN - 1; i >= 0; i--)
        begin
            if (!stop && w[i] == w[XLEN-1])
            begin
                run = run + COUNT_ONE;
            end
            else
            begin
                stop = 1'b1;
            end
        end
        return (w == WORD_ZERO) ? COUNT_ZERO : run - COUNT_ONE;
    endfunction : lead_sign

    function automatic logic [5:0] pop_count(bma_word_t w);
        logic [5:0] n;
        n = COUNT_ZERO;
        for (int i = 0; i < XLEN; i++)
        begin
            n = n + 6'(w[i]);
        end
        return n;
    endfunction : pop_count

    bma_rsp_s rsp_reg;
    bma_rsp_s rsp_next;
    bma_op_e op;
    bma_rs2_s rs2_f;
    logic reg_form;
    logic [4:0] field_len;
    logic [4:0] field_pos;
    logic [5:0] field_sum;
    logic [4:0] field_hi;
    logic [4:0] field_w_m1;
    bma_word_t keep_mask;
    bma_word_t field_mask;
    bma_word_t shifted;
    bma_word_t ext_u;
    bma_word_t ext_s;
    bma_word_t rev_data;
    bma_word_t ror_data;
    logic [4:0] ror_amt;

    assign rs2_f = req.rs2;
    assign op = decode_op(req.instr);
    assign reg_form = (req.instr.opcode == OPC_FIELD_REG);

    // Length and start come from rs2 in register form
    assign field_len = reg_form ? rs2_f.len_m1 : req.instr.length_imm;
    assign field_pos = reg_form ? rs2_f.start : req.instr.position_imm;

    // Field top clips at bit 31
    assign field_sum = {1'b0, field_len} + {1'b0, field_pos};
    assign field_hi = field_sum[5] ? TOP_BIT : field_sum[4:0];
    assign field_w_m1 = field_hi - field_pos;
    assign keep_mask = WORD_ONES >> (TOP_BIT - field_w_m1);
    assign field_mask = keep_mask << field_pos;

    assign shifted = req.rs1 >> field_pos;
    assign ext_u = shifted & keep_mask;
    assign ext_s = shifted[field_w_m1] ? (ext_u | ~keep_mask) : ext_u;

    // Rotate amount is the low five bits only
    assign ror_amt = rs2_f.start;
    assign ror_data = (req.rs1 >> ror_amt) | (req.rs1 << (6'(XLEN) - ror_amt));

    bma_bitrev u_bitrev (
        .operand(req.rs1),
        .position_imm(req.instr.position_imm),
        .group_sel(req.instr.length_imm[1:0]),
        .data(rev_data)
    );

    always_comb
    begin
        rsp_next = rsp_reg;
        if (clk_en)
        begin
            rsp_next.valid = req.valid;
            rsp_next.illegal = 1'b0;
            rsp_next.data = WORD_ZERO;
            if (req.valid)
            begin
                // Disabled extension refuses everything
                if (custom_ext_param != EXT_ENABLED || op == OP_NONE)
                begin
                    rsp_next.illegal = 1'b1;
                end
                else
                begin
                    case (op)
                        OP_EXT_S: rsp_next.data = ext_s;
                        OP_EXT_U: rsp_next.data = ext_u;
                        // Clipping at bit 31 covers misuse only partly
                        OP_DEPOSIT: rsp_next.data = (req.rd_old & ~field_mask) |
                            ((req.rs1 << field_pos) & field_mask);
                        OP_CLR: rsp_next.data = req.rs1 & ~field_mask;
                        OP_SET: rsp_next.data = req.rs1 | field_mask;
                        OP_BITREV: rsp_next.data = rev_data;
                        OP_ROR: rsp_next.data = ror_data;
                        OP_FF1: rsp_next.data =
                            bma_word_t'(find_first(req.rs1));
                        OP_FL1: rsp_next.data =
                            bma_word_t'(find_last(req.rs1));
                        OP_CLB: rsp_next.data =
                            bma_word_t'(lead_sign(req.rs1));
                        OP_CNT: rsp_next.data =
                            bma_word_t'(pop_count(req.rs1));
                        default: rsp_next.illegal = 1'b1;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rsp_reg <= '0;
        end
        else
        begin
            rsp_reg <= rsp_next;
        end
    end

    assign rsp = rsp_reg;

    // Checks on the registered result and on the register-form field sources
    logic fire;
    assign fire = clk_en && req.valid && custom_ext_param == EXT_ENABLED;

    AST_EXTS_SIGN: assert property (@(posedge sys_clk) disable iff (!resetn)
        (fire && op == OP_EXT_S && req.rs1[field_hi]) |=> rsp.data[XLEN-1])
        else $error("signed extract lost its sign");

    AST_EXTU_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn)
        (fire && op == OP_EXT_U) |=> (rsp.data & ~$past(keep_mask)) == WORD_ZERO)
        else $error("unsigned extract not zero-extended");

    AST_REG_FIELDS: assert property (@(posedge sys_clk) disable iff (!resetn)
        (reg_form) |-> (field_len == req.rs2[9:5] && field_pos == req.rs2[4:0]))
        else $error("register form field source wrong");

    AST_DEPOSIT_KEEP: assert property (@(posedge sys_clk) disable iff (!resetn)
        (fire && op == OP_DEPOSIT) |=> ((rsp.data & ~$past(field_mask)) ==
            ($past(req.rd_old) & ~$past(field_mask))))
        else $error("deposit disturbed bits outside field");

    AST_CLR_FIELD: assert property (@(posedge sys_clk) disable iff (!resetn)
        (fire && op == OP_CLR) |=> (rsp.data == ($past(req.rs1) & ~$past(field_mask))))
        else $error("clear field result wrong");

    AST_SET_FIELD: assert property (@(posedge sys_clk) disable iff (!resetn)
        (fire && op == OP_SET) |=> (rsp.data == ($past(req.rs1) | $past(field_mask))))
        else $error("set field result wrong");

    AST_FF1_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn)
        (fire && op == OP_FF1 && req.rs1 == WORD_ZERO) |=> rsp.data == 32'h0000_0020)
        else $error("find first of zero not 32");

    AST_FL1_TOP: assert property (@(posedge sys_clk) disable iff (!resetn)
        (fire && op == OP_FL1 && req.rs1[XLEN-1]) |=> rsp.data == 32'h0000_001f)
        else $error("find last with top bit not 31");

    AST_CLB_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn)
        (fire && op == OP_CLB && req.rs1 == WORD_ZERO) |=> rsp.data == WORD_ZERO)
        else $error("leading sign count of zero not 0");

    AST_CNT_ONES: assert property (@(posedge sys_clk) disable iff (!resetn)
        (fire && op == OP_CNT && req.rs1 == WORD_ONES) |=> rsp.data == 32'h0000_0020)
        else $error("population count of all ones not 32");

    AST_DISABLED: assert property (@(posedge sys_clk) disable iff (!resetn)
        (clk_en && req.valid && custom_ext_param != EXT_ENABLED)
            |=> (rsp.valid && rsp.illegal))
        else $error("disabled extension accepted an operation");

    AST_ROR_AMT: assert property (@(posedge sys_clk) disable iff (!resetn)
        (fire && op == OP_ROR && req.rs2[4:0] == RS2_NONE)
            |=> rsp.data == $past(req.rs1))
        else $error("rotate by zero changed operand");

endmodule : bma_alu

/* File: verilog/bma_pkg.sv */
// Constants, encodings and carrier types for the bit-manipulation ALU
package bma_pkg;

    localparam int XLEN = 32;
    localparam int EXT_ENABLED = 1;

    typedef logic [XLEN-1:0] bma_word_t;

    // Major opcodes and minor function codes
    localparam logic [6:0] OPC_FIELD_IMM = 7'h5b;
    localparam logic [6:0] OPC_FIELD_REG = 7'h2b;
    localparam logic [2:0] F3_EXT_DEP = 3'h0;
    localparam logic [2:0] F3_CLR_SET = 3'h1;
    localparam logic [2:0] F3_REG = 3'h3;

    localparam logic [1:0] F2_EXT_S = 2'h0;
    localparam logic [1:0] F2_EXT_U = 2'h1;
    localparam logic [1:0] F2_DEPOSIT = 2'h2;
    localparam logic [1:0] F2_CLR = 2'h0;
    localparam logic [1:0] F2_SET = 2'h1;
    localparam logic [1:0] F2_BITREV = 2'h3;
    localparam logic [2:0] BITREV_PAD = 3'h0;

    localparam logic [6:0] F7_EXT_S = 7'h18;
    localparam logic [6:0] F7_EXT_U = 7'h19;
    localparam logic [6:0] F7_DEPOSIT = 7'h1a;
    localparam logic [6:0] F7_CLR = 7'h1c;
    localparam logic [6:0] F7_SET = 7'h1d;
    localparam logic [6:0] F7_ROR = 7'h20;
    localparam logic [6:0] F7_FF1 = 7'h21;
    localparam logic [6:0] F7_FL1 = 7'h22;
    localparam logic [6:0] F7_CLB = 7'h23;
    localparam logic [6:0] F7_CNT = 7'h24;
    localparam logic [4:0] RS2_NONE = 5'h00;

    // Field limits and fixed results
    localparam logic [4:0] TOP_BIT = 5'h1f;
    localparam logic [5:0] WORD_BITS = 6'h20;
    localparam logic [5:0] COUNT_ZERO = 6'h00;
    localparam logic [5:0] COUNT_ONE = 6'h01;
    localparam bma_word_t WORD_ZERO = 32'h0000_0000;
    localparam bma_word_t WORD_ONES = 32'hffff_ffff;

    // Radix group selectors
    localparam logic [1:0] GRP_R2 = 2'h0;
    localparam logic [1:0] GRP_R4 = 2'h1;
    localparam logic [1:0] GRP_R8 = 2'h2;
    localparam logic [1:0] GRP_ALIAS = 2'h3;

    typedef enum logic [3:0] {
        OP_NONE, OP_EXT_S, OP_EXT_U, OP_DEPOSIT, OP_CLR, OP_SET,
        OP_BITREV, OP_ROR, OP_FF1, OP_FL1, OP_CLB, OP_CNT
    } bma_op_e;

    // Instruction word; funct7 of register form is {subop_select, len}
    typedef struct packed {
        logic [1:0] subop_select;
        logic [4:0] length_imm;
        logic [4:0] position_imm;
        logic [4:0] src1_idx;
        logic [2:0] funct3;
        logic [4:0] dest_idx;
        logic [6:0] opcode;
    } bma_instr_s;

    typedef struct packed {
        logic [21:0] unused;
        logic [4:0] len_m1;
        logic [4:0] start;
    } bma_rs2_s;

    typedef struct packed {
        logic valid;
        bma_instr_s instr;
        bma_word_t rs1;
        bma_word_t rs2;
        bma_word_t rd_old;
    } bma_req_s;

    typedef struct packed {
        logic valid;
        logic illegal;
        bma_word_t data;
    } bma_rsp_s;

endpackage : bma_pkg

/* File: verilog/bma_bitrev.sv */
// Radix bit-reverse network for FFT index generation
`timescale 1ns/1ns
module bma_bitrev
    import bma_pkg::*;
(
    input wire bma_word_t operand,
    input wire logic [4:0] position_imm,
    input wire logic [1:0] group_sel,
    output bma_word_t data
);
    localparam int R4_GROUPS = XLEN / 2;
    localparam int R8_GROUPS = XLEN / 3;
    localparam int R8_USED = 3 * R8_GROUPS;

    bma_word_t shifted;
    bma_word_t rev2;
    bma_word_t rev4;
    bma_word_t rev8;

    // Top position_imm bits drop out before reversal
    assign shifted = operand << position_imm;

    genvar gi;
    generate
        for (gi = 0; gi < XLEN; gi++)
        begin : g_r2
            assign rev2[gi] = shifted[XLEN-1-gi];
        end
        for (gi = 0; gi < R4_GROUPS; gi++)
        begin : g_r4
            assign rev4[2*gi+1 -: 2] = shifted[XLEN-1-2*gi -: 2];
        end
        for (gi = 0; gi < R8_GROUPS; gi++)
        begin : g_r8
            assign rev8[3*gi+2 -: 3] = shifted[XLEN-1-3*gi -: 3];
        end
    endgenerate

    // Bits left over by whole triples read as zero
    assign rev8[XLEN-1:R8_USED] = '0;

    always_comb
    begin
        case (group_sel)
            GRP_R2: data = rev2;
            GRP_R4: data = rev4;
            GRP_R8: data = rev8;
            GRP_ALIAS: data = rev2;
            default: data = rev2;
        endcase
    end

endmodule : bma_bitrev

/* File: verification/bma_decode_model.sv */
// Behavioural decode stage that presents requests to the ALU
`timescale 1ns/1ns
module bma_decode_model
    import bma_pkg::*;
(
    input wire logic sys_clk,
    output bma_req_s req,
    output logic clk_en
);
    initial
    begin
        req = '0;
        clk_en = 1'b1;
    end

    // Drives on the falling edge; en low models a stalled pipeline
    task automatic issue(input bma_instr_s ins, input bma_word_t a,
        input bma_word_t b, input bma_word_t d, input logic en);
        @(negedge sys_clk);
        req = '{1'b1, ins, a, b, d};
        clk_en = en;
    endtask : issue

    // Operands mean nothing when idle, so they toggle instead of holding
    task automatic idle();
        @(negedge sys_clk);
        req = {1'b0, ~req.instr, ~req.rs1, ~req.rs2, ~req.rd_old};
        clk_en = 1'b1;
    endtask : idle
endmodule : bma_decode_model

/* File: verification/bit_manipulation_alu_bench.sv */
// Self-checking bench for the bit-manipulation ALU
`timescale 1ns/1ns
module bit_manipulation_alu_bench
    import bma_pkg::*;
;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en;
    bma_req_s req;
    bma_rsp_s rsp;
    bma_rsp_s rsp_off;
    bma_rsp_s hold;
    bma_instr_s ins;
    int seed = 21;
    int fails = 0;
    int samples_checked = 0;
    int k;
    int bad_base [0:6] = '{12, 5, 0, 3, 6, 0, 6};
    logic [1:0] f2_tab [0:5] = '{F2_EXT_S, F2_EXT_U, F2_DEPOSIT, F2_CLR,
        F2_SET, F2_BITREV};
    logic [6:0] f7_tab [0:9] = '{F7_EXT_S, F7_EXT_U, F7_DEPOSIT, F7_CLR,
        F7_SET, F7_ROR, F7_FF1, F7_FL1, F7_CLB, F7_CNT};
    bma_word_t corner [0:5] = '{WORD_ZERO, WORD_ONES, 32'h0000_0001,
        32'h8000_0000, 32'h7fff_ffff, 32'h0000_0010};

    always #5 sys_clk = ~sys_clk;

    bma_decode_model bma_decode_model_inst (.sys_clk(sys_clk), .req(req),
        .clk_en(clk_en));
    bma_alu bma_alu_inst (.sys_clk(sys_clk), .resetn(resetn),
        .clk_en(clk_en), .req(req), .rsp(rsp));
    // A build without the extension must refuse every encoding
    bma_alu #(.custom_ext_param(0)) bma_alu_disabled_inst (.sys_clk(sys_clk),
        .resetn(resetn), .clk_en(clk_en), .req(req), .rsp(rsp_off));

    function automatic bma_word_t ref_calc(input bma_instr_s i,
        input bma_word_t a, input bma_word_t b, input bma_word_t d,
        output logic bad);
        bma_word_t m;
        bma_word_t r;
        bma_word_t s;
        bma_op_e op;
        int len;
        int pos;
        int hi;
        int g;
        int lo1;
        int hi1;
        int run;
        op = OP_NONE;
        len = i.length_imm;
        pos = i.position_imm;
        if (i.opcode == OPC_FIELD_IMM && i.funct3 == F3_EXT_DEP)
            if (i.subop_select != F2_BITREV)
                op = bma_op_e'(OP_EXT_S + i.subop_select);
        if (i.opcode == OPC_FIELD_IMM && i.funct3 == F3_CLR_SET)
            if (i.subop_select < F2_DEPOSIT)
                op = bma_op_e'(OP_CLR + i.subop_select);
            else if (i.subop_select == F2_BITREV &&
                i.length_imm[4:2] == BITREV_PAD)
                op = OP_BITREV;
        if (i.opcode == OPC_FIELD_REG && i.funct3 == F3_REG)
        begin
            len = b[9:5];
            pos = b[4:0];
            for (int n = 0; n < 10; n++)
                if ({i.subop_select, i.length_imm} == f7_tab[n])
                    op = bma_op_e'(n < 5 ? n + 1 : n + 2);
            if (op > OP_ROR && i.position_imm != RS2_NONE)
                op = OP_NONE;
        end
        hi = (len + pos > 31) ? 31 : len + pos;
        m = (WORD_ONES >> (31 - hi)) & (WORD_ONES << pos);
        s = a << i.position_imm;
        g = (i.length_imm[1:0] == GRP_R4) ? 2 : 1;
        if (i.length_imm[1:0] == GRP_R8)
            g = 3;
        lo1 = 32;
        hi1 = 32;
        run = 0;
        for (int n = 31; n >= 0; n--)
            if (a[n])
                lo1 = n;
        for (int n = 0; n < 32; n++)
            if (a[n])
                hi1 = n;
        while (run < 32 && a[31 - run] == a[31])
            run++;
        r = WORD_ZERO;
        case (op)
            OP_EXT_S, OP_EXT_U:
                r = (a & m) >> pos;
            OP_DEPOSIT:
                r = (d & ~m) | ((a << pos) & m);
            OP_CLR:
                r = a & ~m;
            OP_SET:
                r = a | m;
            OP_ROR:
                r = (a >> b[4:0]) | (a << (6'h20 - b[4:0]));
            OP_FF1:
                r = bma_word_t'(lo1);
            OP_FL1:
                r = bma_word_t'(hi1);
            OP_CLB:
                r = (a == WORD_ZERO) ? WORD_ZERO : bma_word_t'(run - 1);
            OP_CNT:
                r = bma_word_t'($countones(a));
            OP_BITREV:
                for (int n = 0; n < 32 - 32 % g; n++)
                    r[n] = s[32 - g - (n / g) * g + n % g];
            default:
                r = WORD_ZERO;
        endcase
        if (op == OP_EXT_S && a[hi])
            r = r | ((WORD_ONES << (hi - pos)) << 1);
        bad = (op == OP_NONE);
        return r;
    endfunction : ref_calc

    function automatic bma_instr_s mk(input int k);
        bma_instr_s i;
        i = $random(seed);
        if (k < 6)
        begin
            i.opcode = OPC_FIELD_IMM;
            i.funct3 = (k < 3) ? F3_EXT_DEP : F3_CLR_SET;
            i.subop_select = f2_tab[k];
            if (k == 5)
                i.length_imm[4:2] = BITREV_PAD;
            if (k == 2 && i.length_imm + i.position_imm > 31)
                i.length_imm = 5'h1f - i.position_imm;
        end
        else
        begin
            i.opcode = OPC_FIELD_REG;
            i.funct3 = F3_REG;
            {i.subop_select, i.length_imm} = f7_tab[k - 6];
            if (k > 11)
                i.position_imm = RS2_NONE;
        end
        return i;
    endfunction : mk

    task automatic check_word(input bma_word_t got, input bma_word_t exp,
        input string what);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp,
        input string what);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL %0t %s got %b want %b", $time, what, got, exp);
        end
    endtask : check_bit

    // Result is checked before the next falling edge, so ops run back to back
    task automatic do_op(input bma_instr_s ins, input bma_word_t a,
        input bma_word_t b, input bma_word_t d);
        bma_word_t e;
        logic bad;
        e = ref_calc(ins, a, b, d, bad);
        bma_decode_model_inst.issue(ins, a, b, d, 1'b1);
        @(posedge sys_clk);
        #1;
        check_bit(rsp.valid, 1'b1, "valid");
        check_bit(rsp.illegal, bad, "illegal flag");
        check_word(rsp.data, e, "result");
        check_bit(rsp_off.illegal, 1'b1, "disabled flag");
        check_word(rsp_off.data, WORD_ZERO, "disabled data");
    endtask : do_op

    task automatic run_op(input int kind, input bma_word_t a);
        bma_word_t b;
        b = $random(seed);
        if (kind == 8 && b[9:5] + b[4:0] > 31)
            b[9:5] = 5'h1f - b[4:0];
        do_op(mk(kind), a, b, bma_word_t'($random(seed)));
    endtask : run_op

    task automatic run_range(input int lo, input int hi);
        for (int j = lo; j <= hi; j++)
            repeat (30) run_op(j, $random(seed));
    endtask : run_range

    task automatic do_reset();
        bma_decode_model_inst.idle();
        resetn = 1'b0;
        #1;
        check_word(rsp.data, WORD_ZERO, "data in reset");
        check_bit(rsp.valid, 1'b0, "valid in reset");
        repeat (20) @(negedge sys_clk);
        resetn = 1'b1;
    endtask : do_reset

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    initial
    begin
        #50000;
        fails++;
        $display("FAIL %0t watchdog expired", $time);
        print_verdict();
    end

    initial
    begin
        do_reset();
        run_range(0, 2);
        run_range(3, 5);
        run_range(6, 10);
        run_range(11, 15);
        foreach (corner[c])
            for (k = 0; k < 16; k++)
                run_op(k, corner[c]);
        for (k = 0; k < 11; k++)
        begin
            ins = mk(k);
            if (k < 5)
                ins.length_imm = (k == 2) ? 5'h00 : 5'h1f;
            if (k < 5)
                ins.position_imm = 5'h1f;
            if (k != 5)
                do_op(ins, $random(seed), (k == 8) ? 32'hffff_fc1f :
                    WORD_ONES, $random(seed));
        end
        for (k = 0; k < 4; k++)
        begin
            ins = mk(5);
            ins.length_imm = {BITREV_PAD, 2'(k)};
            do_op(ins, $random(seed), WORD_ZERO, WORD_ZERO);
        end
        ins.length_imm = {BITREV_PAD, GRP_R8};
        ins.position_imm = 5'h04;
        do_op(ins, 32'hc64a_5933, WORD_ZERO, WORD_ZERO);
        check_word(rsp.data, 32'h216b_244b, "radix-8 case");
        for (k = 0; k < 7; k++)
        begin
            ins = mk(bad_base[k]);
            case (k)
                0: ins.position_imm = 5'h01;
                1: ins.length_imm[4] = 1'b1;
                2: ins.subop_select = F2_BITREV;
                3: ins.subop_select = F2_DEPOSIT;
                4: ins.length_imm = 5'h1b;
                5: ins.opcode = 7'h33;
                default: ins.funct3 = 3'h2;
            endcase
            do_op(ins, $random(seed), $random(seed), $random(seed));
            check_bit(rsp.illegal, 1'b1, "bad encoding");
        end
        run_op(11, $random(seed));
        hold = rsp;
        bma_decode_model_inst.issue(mk(15), WORD_ONES, WORD_ZERO, WORD_ZERO,
            1'b0);
        @(posedge sys_clk);
        #1;
        check_word(rsp.data, hold.data, "held while stalled");
        bma_decode_model_inst.idle();
        @(posedge sys_clk);
        #1;
        check_bit(rsp.valid, 1'b0, "valid after idle");
        do_reset();
        for (k = 0; k < 16; k++)
            run_op(k, $random(seed));
        print_verdict();
    end
endmodule : bit_manipulation_alu_bench
